// *** design/epdrw_cmd.sv ***
// epdrw_cmd: serial command interpreter for ram window and pattern commands
// assumes link pins are asynchronous to MCLK_I and sclk is well below 50 MHz
//
// What this block does
// - 3Fh byte sets end option, reset 02h
// - 41h bit 0 selects ram read plane
// - 44h sets 6-bit x window start, end
// - 45h sets 9-bit y window start, end
// - 46h fills secondary plane with checker pattern
// - 47h fills black/white plane identically
// - pattern height and width codes, invalid ignored
// - 4Eh loads 6-bit x address counter
// - 4Fh loads 9-bit y counter, low first
// - 7Fh changes nothing, ends ram bursts
// - 4-wire: msb first, dc level selects
// - 3-wire: nine bits, leading dc flag
`timescale 1ns/1ps
module epdrw_cmd
  import epdrw_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic CS_N_I,
  input wire logic DC_I,
  input wire logic MODE_3WIRE_I,
  output logic BUSY_O,
  output logic [7:0] END_UPDATE_OPTION_O,
  output logic READ_PLANE_O,
  output logic [5:0] X_WINDOW_START_O,
  output logic [5:0] X_WINDOW_END_O,
  output logic [8:0] Y_WINDOW_START_O,
  output logic [8:0] Y_WINDOW_END_O,
  output logic [5:0] X_ADDR_O,
  output logic [8:0] Y_ADDR_O,
  output logic BURST_ACTIVE_O,
  output logic BURST_PLANE_O,
  output logic RAM_WR_EN_O,
  output logic RAM_WR_PLANE_O,
  output logic [5:0] RAM_WR_X_O,
  output logic [8:0] RAM_WR_Y_O,
  output logic [7:0] RAM_WR_DATA_O
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic scl_prev_q;
  logic scl_rise;

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      meta_q <= 5'h04;
      sync_q <= 5'h04;
      scl_prev_q <= 1'b0;
    end else begin
      meta_q <= {MODE_3WIRE_I, DC_I, CS_N_I, SDA_I, SCL_I};
      sync_q <= meta_q;
      scl_prev_q <= sync_q[0];
    end
  end

  assign scl_rise = sync_q[0] && !scl_prev_q && !sync_q[2];

  // ---------------------------------------------------------------
  // byte assembly
  // ---------------------------------------------------------------
  logic [8:0] shift_q;
  logic [3:0] nbits_q;
  logic byte_done;
  epdrw_byte_t rx;
  logic mode3_q;

  // mode strap is a pin too: synchronised, and only taken while deselected
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      mode3_q <= 1'b0;
    end else if (sync_q[2]) begin
      mode3_q <= sync_q[4];
    end
  end

  assign byte_done = scl_rise &&
    (nbits_q == (mode3_q ? 4'(BITS_3W - 1) : 4'(BITS_4W - 1)));

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      shift_q <= '0;
      nbits_q <= '0;
    end else if (sync_q[2]) begin
      nbits_q <= '0;
    end else if (scl_rise) begin
      shift_q <= {shift_q[7:0], sync_q[1]};
      nbits_q <= byte_done ? 4'h0 : nbits_q + 4'h1;
    end
  end

  // 3-wire: flag is the first of nine; 4-wire: pin level during last bit
  assign rx.is_data = mode3_q ? shift_q[7] : sync_q[3];
  assign rx.value = {shift_q[6:0], sync_q[1]};

  // ---------------------------------------------------------------
  // command decode and parameter storage
  // ---------------------------------------------------------------
  logic [7:0] cmd_q;
  logic [1:0] idx_q;
  logic fill_busy;
  logic fill_start;
  epdrw_fill_t fill_cfg;
  logic data_ok;

  // commands issued while a fill runs are dropped
  assign data_ok = byte_done && rx.is_data && !fill_busy;

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cmd_q <= CMD_NOP;
      idx_q <= '0;
    end else if (byte_done && !fill_busy) begin
      if (!rx.is_data) begin
        cmd_q <= rx.value;
        idx_q <= '0;
      end else if (idx_q != 2'h3) begin
        idx_q <= idx_q + 2'h1;
      end
    end
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      END_UPDATE_OPTION_O <= END_OPT_RST;
      READ_PLANE_O <= 1'b0;
    end else if (data_ok && idx_q == 2'h0) begin
      if (cmd_q == CMD_END_OPT) begin
        END_UPDATE_OPTION_O <= rx.value;
      end
      if (cmd_q == CMD_READ_SEL) begin
        READ_PLANE_O <= rx.value[0];
      end
    end
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      X_WINDOW_START_O <= X_START_RST;
      X_WINDOW_END_O <= X_END_RST;
    end else if (data_ok && cmd_q == CMD_X_WIN) begin
      if (idx_q == 2'h0) X_WINDOW_START_O <= rx.value[5:0];
      if (idx_q == 2'h1) X_WINDOW_END_O <= rx.value[5:0];
    end
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      Y_WINDOW_START_O <= Y_START_RST;
      Y_WINDOW_END_O <= Y_END_RST;
    end else if (data_ok && cmd_q == CMD_Y_WIN) begin
      unique case (idx_q)
        2'h0: Y_WINDOW_START_O[7:0] <= rx.value;
        2'h1: Y_WINDOW_START_O[8] <= rx.value[0];
        2'h2: Y_WINDOW_END_O[7:0] <= rx.value;
        2'h3: Y_WINDOW_END_O[8] <= rx.value[0];
      endcase
    end
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      X_ADDR_O <= X_CNT_RST;
      Y_ADDR_O <= Y_CNT_RST;
    end else if (data_ok) begin
      if (cmd_q == CMD_X_CNT && idx_q == 2'h0) begin
        X_ADDR_O <= rx.value[5:0];
      end
      if (cmd_q == CMD_Y_CNT && idx_q == 2'h0) begin
        Y_ADDR_O[7:0] <= rx.value;
      end
      if (cmd_q == CMD_Y_CNT && idx_q == 2'h1) begin
        Y_ADDR_O[8] <= rx.value[0];
      end
    end
  end

  // ---------------------------------------------------------------
  // ram burst tracking
  // ---------------------------------------------------------------
  // any command byte ends a burst; nop does only that
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      BURST_ACTIVE_O <= 1'b0;
      BURST_PLANE_O <= 1'b0;
    end else if (byte_done && !rx.is_data && !fill_busy) begin
      BURST_ACTIVE_O <= (rx.value == CMD_WRITE_BW) || (rx.value == CMD_WRITE_SEC);
      BURST_PLANE_O <= (rx.value == CMD_WRITE_SEC);
    end
  end

  // ---------------------------------------------------------------
  // pattern fill
  // ---------------------------------------------------------------
  logic [2:0] hcode;
  logic [2:0] wcode;
  assign hcode = rx.value[PAT_H_LSB +: 3];
  assign wcode = rx.value[PAT_W_LSB +: 3];

  // step size itself, a power of two, masks the address bit that flips the pattern
  always_comb begin
    fill_cfg.first_val = rx.value[PAT_FIRST_BIT];
    fill_cfg.plane = (cmd_q == CMD_FILL_BW);
    // height 296 covers the whole panel, so no flip in y
    fill_cfg.step_h = (hcode == 3'h6) ? 9'h000 : 9'(9'h008 << hcode);
    // width 176 covers the whole row, so no flip in x
    fill_cfg.step_w = (wcode == PAT_W_MAX) ? 8'h00 : 8'(8'h08 << wcode);
  end

  assign fill_start = data_ok && idx_q == 2'h0 &&
    (cmd_q == CMD_FILL_SEC || cmd_q == CMD_FILL_BW) &&
    hcode != PAT_H_BAD && wcode <= PAT_W_MAX;

  epdrw_fill u_fill (
    .clk_i(MCLK_I),
    .rst_i(RESET_I),
    .start_i(fill_start),
    .cfg_i(fill_cfg),
    .busy_o(fill_busy),
    .wr_en_o(RAM_WR_EN_O),
    .wr_plane_o(RAM_WR_PLANE_O),
    .wr_x_o(RAM_WR_X_O),
    .wr_y_o(RAM_WR_Y_O),
    .wr_data_o(RAM_WR_DATA_O)
  );

  assign BUSY_O = fill_busy;

endmodule : epdrw_cmd

// *** design/epdrw_fill.sv ***
// epdrw_fill: walks the whole ram writing a checker pattern, one byte a cycle
// assumes start is a one-cycle pulse given only when idle
`timescale 1ns/1ps
module epdrw_fill
  import epdrw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire epdrw_fill_t cfg_i,
  output logic busy_o,
  output logic wr_en_o,
  output logic wr_plane_o,
  output logic [5:0] wr_x_o,
  output logic [8:0] wr_y_o,
  output logic [7:0] wr_data_o
);
  typedef enum logic {EPDRW_IDLE, EPDRW_RUN} epdrw_fst_t;
  epdrw_fst_t st_q;
  epdrw_fill_t cfg_q;
  logic [5:0] x_q;
  logic [8:0] y_q;
  logic [8:0] xpix;
  logic yband;
  logic [7:0] pix;
  logic last;

  assign last = (x_q == 6'(FILL_COLS - 1)) && (y_q == 9'(FILL_ROWS - 1));
  assign yband = |(y_q & cfg_q.step_h);
  assign xpix = {x_q, 3'h0};

  // one generate loop builds the eight pixels of a byte
  for (genvar b = 0; b < 8; b++) begin : g_pix
    assign pix[7 - b] = cfg_q.first_val ^ yband ^ |((xpix + 9'(b)) & {1'b0, cfg_q.step_w});
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= EPDRW_IDLE;
      cfg_q <= '0;
      x_q <= '0;
      y_q <= '0;
    end else begin
      unique case (st_q)
        EPDRW_IDLE: begin
          if (start_i) begin
            st_q <= EPDRW_RUN;
            cfg_q <= cfg_i;
            x_q <= '0;
            y_q <= '0;
          end
        end
        EPDRW_RUN: begin
          if (last) begin
            st_q <= EPDRW_IDLE;
          end else if (x_q == 6'(FILL_COLS - 1)) begin
            x_q <= '0;
            y_q <= y_q + 9'h1;
          end else begin
            x_q <= x_q + 6'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_en_o <= 1'b0;
      wr_plane_o <= 1'b0;
      wr_x_o <= '0;
      wr_y_o <= '0;
      wr_data_o <= '0;
    end else begin
      wr_en_o <= (st_q == EPDRW_RUN);
      wr_plane_o <= cfg_q.plane;
      wr_x_o <= x_q;
      wr_y_o <= y_q;
      wr_data_o <= pix;
    end
  end

  // busy covers the registered last write too
  assign busy_o = (st_q == EPDRW_RUN) || wr_en_o;

endmodule : epdrw_fill

// *** dv/epdrw_cmd_checker.sv ***
// epdrw_cmd_checker: port assertions for the command logic
// assumes one clock domain, bound to every epdrw_cmd
`timescale 1ns/1ps
module epdrw_cmd_checker
  import epdrw_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic BUSY_O,
  input wire logic [7:0] END_UPDATE_OPTION_O,
  input wire logic [5:0] X_WINDOW_END_O,
  input wire logic RAM_WR_EN_O,
  input wire logic [5:0] RAM_WR_X_O,
  input wire logic [8:0] RAM_WR_Y_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  a_reset_values: assert property ($fell(RESET_I) |->
    END_UPDATE_OPTION_O == END_OPT_RST && X_WINDOW_END_O == X_END_RST)
    else $error("register not at reset value");
  a_busy_drops: assert property (BUSY_O |=> $stable(END_UPDATE_OPTION_O))
    else $error("byte taken while busy");
  a_write_busy: assert property (RAM_WR_EN_O |-> BUSY_O)
    else $error("fill write without busy");
  a_write_range: assert property (RAM_WR_EN_O |-> RAM_WR_X_O < 6'h16 && RAM_WR_Y_O < 9'h128)
    else $error("fill write outside ram");
  a_x_step: assert property (RAM_WR_EN_O && RAM_WR_X_O < 6'h15 |=> RAM_WR_EN_O
    && RAM_WR_X_O == $past(RAM_WR_X_O) + 6'h01) else $error("fill column skipped");
  a_row_step: assert property (RAM_WR_EN_O && RAM_WR_X_O == 6'h15 && RAM_WR_Y_O < 9'h127
    |=> RAM_WR_EN_O && RAM_WR_X_O == 6'h00 && RAM_WR_Y_O == $past(RAM_WR_Y_O) + 9'h001)
    else $error("fill row skipped");
  a_first_write: assert property ($rose(BUSY_O) |=> RAM_WR_EN_O
    && RAM_WR_X_O == 6'h00 && RAM_WR_Y_O == 9'h000) else $error("fill start wrong");
  a_busy_end: assert property ($fell(BUSY_O) |-> $past(RAM_WR_EN_O)
    && $past(RAM_WR_X_O) == 6'h15 && $past(RAM_WR_Y_O) == 9'h127)
    else $error("busy fell early");
endmodule : epdrw_cmd_checker

bind epdrw_cmd epdrw_cmd_checker i_chk (.MCLK_I, .RESET_I, .BUSY_O, .END_UPDATE_OPTION_O,
  .X_WINDOW_END_O, .RAM_WR_EN_O, .RAM_WR_X_O, .RAM_WR_Y_O);

// *** dv/epdrw_cmd_test.sv ***
// epdrw_cmd_test: random command traffic in both link modes, then corner and full pattern fills in 3-wire mode only
// assumes the host model and bound checker from dv/
`timescale 1ns/1ps
module epdrw_cmd_test
  import epdrw_pkg::*;
();
  logic MCLK_I = 1'b0;
  logic RESET_I = 1'b1;
  logic MODE_3WIRE_I = 1'b0;
  logic scl, sda, cs_n, dc, busy, rplane, burst, bplane, wr_en, wr_plane;
  logic [7:0] end_update_option, wr_data;
  logic [5:0] xs, xe, xa, wr_x;
  logic [8:0] ys, ye, ya, wr_y;
  int err_total = 0;
  int comparisons = 0;
  int writes = 0;
  logic [7:0] pat_q = 8'h00;
  logic plane_q = 1'b0;
  logic [31:0] lfsr_q = 32'h208d;
  logic [31:0] p;

  always #5 MCLK_I = ~MCLK_I;

  epdrw_host i_host (.mode_3wire_i(MODE_3WIRE_I), .scl_o(scl), .sda_o(sda), .cs_n_o(cs_n),
    .dc_o(dc));
  epdrw_cmd i_dut (.MCLK_I, .RESET_I, .SCL_I(scl), .SDA_I(sda), .CS_N_I(cs_n), .DC_I(dc),
    .MODE_3WIRE_I, .BUSY_O(busy), .END_UPDATE_OPTION_O(end_update_option), .READ_PLANE_O(rplane),
    .X_WINDOW_START_O(xs), .X_WINDOW_END_O(xe), .Y_WINDOW_START_O(ys), .Y_WINDOW_END_O(ye),
    .X_ADDR_O(xa), .Y_ADDR_O(ya), .BURST_ACTIVE_O(burst), .BURST_PLANE_O(bplane),
    .RAM_WR_EN_O(wr_en), .RAM_WR_PLANE_O(wr_plane), .RAM_WR_X_O(wr_x), .RAM_WR_Y_O(wr_y),
    .RAM_WR_DATA_O(wr_data));

  function automatic logic [7:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q[7:0];
  endfunction : rnd

  // codes 110 and 101 span the panel, so they never flip
  function automatic logic [7:0] pat_byte(input logic [7:0] c, input logic [5:0] x,
                                          input logic [8:0] y);
    logic [8:0] h;
    logic [8:0] w;
    h = (c[6:4] == 3'h6) ? 9'h000 : 9'h008 << c[6:4];
    w = (c[2:0] == 3'h5) ? 9'h000 : 9'h008 << c[2:0];
    for (int b = 0; b < 8; b++) begin
      pat_byte[b] = c[7] ^ (|(y & h)) ^ (|(({x, 3'h0} + 9'(7 - b)) & w));
    end
  endfunction : pat_byte

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cmd(input logic [7:0] c, input logic [31:0] v, input int n);
    i_host.send(1'b0, c);
    for (int i = 0; i < n; i++) i_host.send(1'b1, v[8*i +: 8]);
    repeat (4) @(negedge MCLK_I);
  endtask : cmd

  task automatic fill(input logic [7:0] c, input logic [7:0] v, input int n);
    pat_q = v;
    plane_q = (c == CMD_FILL_BW);
    writes = 0;
    cmd(CMD_END_OPT, 32'(END_OPT_KEEP), 1);
    cmd(c, {24'h0, v}, 1);
    chk("busy", 16'(n != 0), 16'(busy));
    // taken only when no fill runs; dropped while busy
    cmd(CMD_END_OPT, 32'(END_OPT_NORMAL), 1);
    for (int i = 0; i < 7000 && busy !== 1'b0; i++) @(negedge MCLK_I);
    chk("busy", 16'h0, 16'(busy));
    chk("fill writes", 16'(n), 16'(writes));
    chk("end option", 16'(n != 0 ? END_OPT_KEEP : END_OPT_NORMAL), 16'(end_update_option));
  endtask : fill

  // sampled mid-cycle, away from the edge that launches each write
  always @(negedge MCLK_I) begin
    if (wr_en === 1'b1) begin
      writes <= writes + 1;
      chk("fill byte", 16'(pat_byte(pat_q, wr_x, wr_y)), 16'(wr_data));
      chk("fill plane", 16'(plane_q), 16'(wr_plane));
    end
  end

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  initial begin
    #600us;
    err_total++;
    finish_test();
  end

  initial begin
    repeat (3) @(negedge MCLK_I);
    RESET_I = 1'b0;
    repeat (4) @(negedge MCLK_I);
    chk("end option", 16'(END_OPT_RST), 16'(end_update_option));
    chk("read plane", 16'h0, 16'(rplane));
    chk("x window", 16'(X_END_RST), 16'({xs, xe}));
    chk("address", 16'h0, 16'({xa, ya}));
    for (int m = 0; m < 2; m++) begin
      MODE_3WIRE_I = m[0];
      repeat (4) @(negedge MCLK_I);
      cmd(CMD_END_OPT, 32'(END_OPT_NORMAL), 1);
      chk("end option", 16'(END_OPT_NORMAL), 16'(end_update_option));
      cmd(CMD_END_OPT, 32'(END_OPT_KEEP), 1);
      chk("end option", 16'(END_OPT_KEEP), 16'(end_update_option));
      p = {rnd(), rnd(), rnd(), rnd()};
      cmd(CMD_READ_SEL, p, 1);
      chk("read plane", 16'(p[0]), 16'(rplane));
      cmd(CMD_X_WIN, p, 2);
      chk("x window", 16'({p[5:0], p[13:8]}), 16'({xs, xe}));
      cmd(CMD_Y_WIN, p, 4);
      chk("y start", 16'({p[8], p[7:0]}), 16'(ys));
      chk("y end", 16'({p[24], p[23:16]}), 16'(ye));
      cmd(CMD_X_CNT, p, 1);
      chk("x addr", 16'(p[5:0]), 16'(xa));
      cmd(CMD_Y_CNT, p, 2);
      chk("y addr", 16'({p[8], p[7:0]}), 16'(ya));
      cmd(m[0] ? CMD_WRITE_SEC : CMD_WRITE_BW, 32'h0, 0);
      chk("burst", 16'({1'b1, m[0]}), 16'({burst, bplane}));
      cmd(CMD_NOP, 32'h0, 0);
      chk("burst", 16'h0, 16'(burst));
      chk("y addr", 16'({p[8], p[7:0]}), 16'(ya));
    end
    fill(CMD_FILL_SEC, {rnd() | 8'h70}, 0);
    fill(CMD_FILL_BW, 8'h06, 0);
    fill(CMD_FILL_BW, 8'h91, 6512);
    fill(CMD_FILL_SEC, 8'h65, 6512);
    fill(CMD_FILL_BW, 8'h2b, 6512);
    fill(CMD_FILL_SEC, 8'hd8, 6512);
    finish_test();
  end
endmodule : epdrw_cmd_test

// *** dv/epdrw_host.sv ***
// epdrw_host: host side of the serial link, one byte per chip-select frame
// assumes the device samples the link pins with its own clock
`timescale 1ns/1ps
module epdrw_host (
  input wire logic mode_3wire_i,
  output logic scl_o,
  output logic sda_o,
  output logic cs_n_o,
  output logic dc_o
);
  initial begin
    scl_o = 1'b0;
    sda_o = 1'b0;
    cs_n_o = 1'b1;
    dc_o = 1'b0;
  end

  task automatic send(input logic dc, input logic [7:0] b);
    logic [8:0] w;
    int n;
    w = {dc, b};
    n = mode_3wire_i ? 9 : 8;
    dc_o = mode_3wire_i ? 1'b0 : dc;
    cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sda_o = w[i];
      #62.5 scl_o = 1'b1;
      #62.5 scl_o = 1'b0;
    end
    #70 cs_n_o = 1'b1;
    // released line shows no stale bit
    sda_o = ~sda_o;
    #120;
  endtask : send
endmodule : epdrw_host

// *** shared/epdrw_pkg.sv ***
// epdrw_pkg: constants and types for the ram window command logic
// assumes a single 100 MHz core clock; serial link pins sampled asynchronously
package epdrw_pkg;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_END_OPT = 8'h3f;
  localparam logic [7:0] CMD_READ_SEL = 8'h41;
  localparam logic [7:0] CMD_X_WIN = 8'h44;
  localparam logic [7:0] CMD_Y_WIN = 8'h45;
  localparam logic [7:0] CMD_FILL_SEC = 8'h46;
  localparam logic [7:0] CMD_FILL_BW = 8'h47;
  localparam logic [7:0] CMD_X_CNT = 8'h4e;
  localparam logic [7:0] CMD_Y_CNT = 8'h4f;
  localparam logic [7:0] CMD_NOP = 8'h7f;
  localparam logic [7:0] CMD_WRITE_BW = 8'h24;
  localparam logic [7:0] CMD_WRITE_SEC = 8'h26;

  // ---------------------------------------------------------------
  // values after reset and option codes
  // ---------------------------------------------------------------
  localparam logic [7:0] END_OPT_RST = 8'h02;
  localparam logic [7:0] END_OPT_NORMAL = 8'h22;
  localparam logic [7:0] END_OPT_KEEP = 8'h07;
  localparam logic [5:0] X_START_RST = 6'h00;
  localparam logic [5:0] X_END_RST = 6'h15;
  localparam logic [8:0] Y_START_RST = 9'h000;
  localparam logic [8:0] Y_END_RST = 9'h000;
  localparam logic [5:0] X_CNT_RST = 6'h00;
  localparam logic [8:0] Y_CNT_RST = 9'h000;
  localparam logic [7:0] PATTERN_RST = 8'h00;

  // ---------------------------------------------------------------
  // pattern byte fields
  // ---------------------------------------------------------------
  localparam int PAT_FIRST_BIT = 7;
  localparam int PAT_H_LSB = 4;
  localparam int PAT_W_LSB = 0;
  localparam logic [2:0] PAT_H_BAD = 3'h7;
  localparam logic [2:0] PAT_W_MAX = 3'h5;
  localparam int FILL_ROWS = 296;
  localparam int FILL_COLS = 22;

  localparam int BITS_4W = 8;
  localparam int BITS_3W = 9;

  typedef struct packed {
    logic first_val;
    logic [8:0] step_h;
    logic [7:0] step_w;
    logic plane;
  } epdrw_fill_t;

  typedef struct packed {
    logic is_data;
    logic [7:0] value;
  } epdrw_byte_t;

endpackage : epdrw_pkg
